// >>> design/lcd_ctrl.sv
// Overview of operation
// RULE_01: Flash read byte is the upper eight bits of the addressed word.
// RULE_02: Flash flags a valid byte; controller samples it only then.
// RULE_03: One clock source drives all logic; no second clock.
// RULE_04: Divided clock tick paces the display state machine.
// RULE_05: Default message read from flash and shown once after init.
// RULE_06: Reset reinitialises display: cursor home, blinking on.
// RULE_07: While host request held low, bytes taken at about 4.25 kHz.
// RULE_08: Row one end jumps the display address to row two start.
// RULE_09: Select low is command, high data; rw low write, high read.
// RULE_10: Strobe falling edge latches or fetches the selected register.
// RULE_11: Host request low starts; ack low once byte reached display.
// RULE_12: Init waits 15 ms per command; data writes poll busy.
// RULE_13: Free-running seven-bit divider counter, top bit is slow clock; the code instead uses a one-cycle tick enable when the counter is all ones.
`timescale 1ns/100ps
`include "lcd_consts.svh"

module lcd_ctrl import lcd_pkg::*; #(
    parameter int INIT_WAIT_CYC = `LCD_CLK_HZ / 1000 * `LCD_INIT_WAIT_MS,
    parameter int HOST_RATE_CYC = `LCD_CLK_HZ / `LCD_HOST_RATE_HZ,
    parameter int FIFO_DEPTH = `LCD_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Host character port
    input wire logic [7:0] host_char_in,
    input wire logic host_we_n,
    output logic host_ack_n,
    // Display module
    input wire logic [7:0] lcd_bus_in,
    output logic [7:0] lcd_bus_out,
    output logic lcd_bus_oe_n,
    output logic lcd_strobe,
    output logic lcd_target_select,
    output logic lcd_rw
);
    localparam int RATE_LAST = HOST_RATE_CYC - 1;
    localparam logic [8*`LCD_MSG_LEN-1:0] MSG_TEXT =
        {" CHARACTER  LCD ", "   CONTROLLER   "};

    lcd_state_t st_reg, st_next;
    lcd_char_t fifo_in, fifo_out;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
    logic tick, apb_done, apb_push, host_push, char_busy, step_done;
    logic [15:0] rom_q;
    logic [7:0] rom_hi;

    function automatic logic [7:0] init_cmd(input logic [2:0] idx);
        unique case (idx)
            3'd0: init_cmd = `LCD_CMD_FUNC;
            3'd1: init_cmd = `LCD_CMD_DISP;
            3'd2: init_cmd = `LCD_CMD_CLEAR;
            3'd3: init_cmd = `LCD_CMD_ENTRY;
            default: init_cmd = `LCD_CMD_HOME;
        endcase
    endfunction : init_cmd

    function automatic logic [15:0] rom_word(input logic [8:0] addr);
        int idx;
        idx = int'(addr);
        if (idx < `LCD_MSG_LEN) begin
            rom_word = {MSG_TEXT[8*(`LCD_MSG_LEN-1-idx) +: 8], 8'h00};
        end else begin
            rom_word = 16'h2000;
        end
    endfunction : rom_word

    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] r);
        reg_hit = (a == r);
    endfunction : reg_hit

    function automatic lcd_pins_t load_wr(input logic sel,
                                          input logic [7:0] b);
        load_wr = '{strobe: 1'b0, target_select: sel, rw: 1'b0,
                    bus_out: b, bus_oe_n: 1'b0};
    endfunction : load_wr

    // The slow clock is an enable, not a clock net: pclk stays sole clock
    assign tick = (st_reg.div == '1); // [RULE_03] [RULE_13]
    assign rom_q = rom_word(st_reg.flash_addr);
    assign rom_hi = rom_q[15:8]; // [RULE_01]

    assign apb_done = psel && penable && st_reg.pready;
    assign apb_push = apb_done && pwrite && !st_reg.pslverr &&
                      reg_hit(paddr, `LCD_REG_CHAR);
    // Host path yields to a pending character-register write so a granted slot stays free
    assign char_busy = psel && pwrite && reg_hit(paddr, `LCD_REG_CHAR);
    assign host_push = st_reg.host_en && !st_reg.we_f && !st_reg.ack_n &&
                       (st_reg.rate_cnt == '0) && fifo_in_ready &&
                       !char_busy; // [RULE_07] [RULE_11]
    assign fifo_in_valid = apb_push || host_push;
    assign fifo_in = apb_push ? {1'b0, pwdata[7:0]}
                              : {1'b1, st_reg.chr_f};
    assign fifo_out_ready = (st_reg.fsm == S_IDLE) && tick &&
                            st_reg.init_done && st_reg.msg_done &&
                            !st_reg.jump_pend && !st_reg.reinit_pend;

    lcd_fifo #(
        .WIDTH($bits(lcd_char_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(fifo_in_valid),
        .in_data(fifo_in),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out),
        .out_ready(fifo_out_ready)
    );

    always_comb begin
        st_next = st_reg;
        step_done = 1'b0;
        st_next.div = st_reg.div + 1'b1; // [RULE_13]
        // Pin inputs: change accepted once stages two and three agree
        st_next.we_sync = {st_reg.we_sync[1:0], host_we_n};
        st_next.chr_sync = {st_reg.chr_sync[1:0], host_char_in};
        st_next.bus_sync = {st_reg.bus_sync[1:0], lcd_bus_in};
        if (st_reg.we_sync[1] == st_reg.we_sync[2]) begin
            st_next.we_f = st_reg.we_sync[2];
        end
        if (st_reg.chr_sync[1] == st_reg.chr_sync[2]) begin
            st_next.chr_f = st_reg.chr_sync[2];
        end
        if (st_reg.bus_sync[1] == st_reg.bus_sync[2]) begin
            st_next.bus_f = st_reg.bus_sync[2];
        end
        // Flash read port: byte valid the cycle after the read strobe
        st_next.flash_valid = !st_reg.flash_nread; // [RULE_02]
        st_next.flash_byte = rom_hi;
        // Host sampling pace
        if (st_reg.rate_cnt == '0) begin
            st_next.rate_cnt = `LCD_RATE_BITS'(RATE_LAST); // [RULE_07]
        end else begin
            st_next.rate_cnt = st_reg.rate_cnt - 1'b1;
        end
        if (host_push) begin
            st_next.ack_n = 1'b1; // [RULE_11]
        end

        unique case (st_reg.fsm)
            S_IDLE: begin
                if (tick) begin // [RULE_04]
                    if (st_reg.reinit_pend) begin
                        st_next.init_done = 1'b0; // [RULE_06]
                        st_next.init_idx = '0;
                        st_next.jump_pend = 1'b0;
                        st_next.reinit_pend = 1'b0;
                    end else if (!st_reg.init_done) begin
                        st_next.lcd = load_wr(1'b0,
                            init_cmd(st_reg.init_idx)); // [RULE_09]
                        st_next.cur_is_cmd = 1'b1;
                        st_next.fsm = S_WR_HI;
                    end else if (st_reg.jump_pend) begin
                        st_next.lcd = load_wr(1'b0, (st_reg.pos == '0) ?
                            `LCD_CMD_HOME : `LCD_CMD_ROW2); // [RULE_08]
                        st_next.cur_is_cmd = 1'b1;
                        st_next.jump_pend = 1'b0;
                        st_next.fsm = S_WR_HI;
                    end else if (!st_reg.msg_done) begin
                        st_next.flash_addr = 9'(st_reg.msg_idx);
                        st_next.flash_nread = 1'b0;
                        st_next.fsm = S_MSG_WAIT;
                    end else if (fifo_out_valid) begin
                        st_next.lcd = load_wr(1'b1, fifo_out.code);
                        st_next.cur_host = fifo_out.from_host;
                        st_next.cur_is_cmd = 1'b0;
                        st_next.fsm = S_WR_HI;
                    end
                end
            end
            S_MSG_WAIT: begin
                st_next.flash_nread = 1'b1;
                if (st_reg.flash_valid) begin // [RULE_02]
                    st_next.lcd = load_wr(1'b1, st_reg.flash_byte);
                    st_next.cur_host = 1'b0;
                    st_next.cur_is_cmd = 1'b0;
                    st_next.msg_idx = st_reg.msg_idx + 1'b1;
                    if (st_reg.msg_idx == 6'(`LCD_MSG_LEN - 1)) begin
                        st_next.msg_done = 1'b1; // [RULE_05]
                    end
                    st_next.fsm = S_WR_HI;
                end
            end
            S_WR_HI: begin
                if (tick) begin
                    st_next.lcd.strobe = 1'b1;
                    st_next.fsm = S_WR_LO;
                end
            end
            S_WR_LO: begin
                if (tick) begin
                    st_next.lcd.strobe = 1'b0; // [RULE_10]
                    if (st_reg.cur_is_cmd && !st_reg.init_done) begin
                        st_next.wait_cnt =
                            `LCD_WAIT_BITS'(INIT_WAIT_CYC - 1); // [RULE_12]
                        st_next.fsm = S_DELAY;
                    end else begin
                        st_next.fsm = S_BUSY_SET;
                    end
                end
            end
            S_DELAY: begin
                if (st_reg.wait_cnt == '0) begin
                    step_done = 1'b1;
                end else begin
                    st_next.wait_cnt = st_reg.wait_cnt - 1'b1;
                end
            end
            S_BUSY_SET: begin
                if (tick) begin
                    // Release the bus before the module may drive it
                    st_next.lcd.target_select = 1'b0; // [RULE_09]
                    st_next.lcd.rw = 1'b1;
                    st_next.lcd.bus_oe_n = 1'b1;
                    st_next.fsm = S_BUSY_HI;
                end
            end
            S_BUSY_HI: begin
                if (tick) begin
                    st_next.lcd.strobe = 1'b1;
                    st_next.fsm = S_BUSY_LO;
                end
            end
            S_BUSY_LO: begin
                if (tick) begin
                    st_next.lcd.strobe = 1'b0; // [RULE_10]
                    if (!st_reg.bus_f[`LCD_BUSY_BIT]) begin // [RULE_12]
                        step_done = 1'b1;
                    end else begin
                        st_next.fsm = S_BUSY_HI;
                    end
                end
            end
        endcase

        if (step_done) begin
            st_next.fsm = S_IDLE;
            if (!st_reg.init_done) begin
                if (st_reg.init_idx == 3'(`LCD_INIT_STEPS - 1)) begin
                    st_next.init_done = 1'b1;
                    st_next.pos = '0; // [RULE_06]
                end else begin
                    st_next.init_idx = st_reg.init_idx + 1'b1;
                end
            end else if (!st_reg.cur_is_cmd) begin
                st_next.pos = st_reg.pos + 1'b1;
                if (st_reg.pos == 5'(`LCD_ROW_LEN - 1) ||
                    st_reg.pos == 5'(`LCD_MSG_LEN - 1)) begin
                    st_next.jump_pend = 1'b1; // [RULE_08]
                end
                if (st_reg.cur_host) begin
                    st_next.ack_n = 1'b0; // [RULE_11]
                end
            end
        end

        // Bus answer, registered; a full queue stalls a character write
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.prdata = '0;
        if (psel && penable && !st_reg.pready) begin
            if (!(reg_hit(paddr, `LCD_REG_CTRL) ||
                  reg_hit(paddr, `LCD_REG_STATUS) ||
                  reg_hit(paddr, `LCD_REG_CHAR))) begin
                st_next.pready = 1'b1;
                st_next.pslverr = 1'b1;
            end else if (!(char_busy && !fifo_in_ready)) begin
                st_next.pready = 1'b1;
                if (!pwrite && reg_hit(paddr, `LCD_REG_CTRL)) begin
                    st_next.prdata[`LCD_CTRL_HOST_EN] = st_reg.host_en;
                end else if (!pwrite) begin
                    st_next.prdata[`LCD_ST_INIT_DONE] = st_reg.init_done;
                    st_next.prdata[`LCD_ST_MSG_DONE] = st_reg.msg_done;
                    st_next.prdata[`LCD_ST_FIFO_FULL] = !fifo_in_ready;
                    st_next.prdata[`LCD_ST_ACK] = st_reg.ack_n;
                    st_next.prdata[`LCD_ST_POS_LSB +: 5] = st_reg.pos;
                    if (reg_hit(paddr, `LCD_REG_CHAR)) begin
                        st_next.prdata = '0;
                    end
                end
            end
        end
        // Reinit request set after the state machine so it is never lost
        if (apb_done && pwrite && reg_hit(paddr, `LCD_REG_CTRL)) begin
            st_next.host_en = pwdata[`LCD_CTRL_HOST_EN];
            if (pwdata[`LCD_CTRL_REINIT]) begin
                st_next.reinit_pend = 1'b1; // [RULE_06]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.we_sync <= '1;
            st_reg.we_f <= 1'b1;
            st_reg.host_en <= `LCD_HOST_EN_RESET;
            st_reg.flash_nread <= 1'b1;
            st_reg.lcd.bus_oe_n <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign host_ack_n = st_reg.ack_n;
    assign lcd_bus_out = st_reg.lcd.bus_out;
    assign lcd_bus_oe_n = st_reg.lcd.bus_oe_n;
    assign lcd_strobe = st_reg.lcd.strobe;
    assign lcd_target_select = st_reg.lcd.target_select;
    assign lcd_rw = st_reg.lcd.rw;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_strobe_fall;
        $fell(st_reg.lcd.strobe);
    endsequence
    sequence s_lines_steady;
        $stable(st_reg.lcd.bus_out) && $stable(st_reg.lcd.target_select)
            && $stable(st_reg.lcd.rw);
    endsequence
    sequence s_msg_taken;
        $past(st_reg.fsm) == S_MSG_WAIT && st_reg.fsm == S_WR_HI;
    endsequence

    chk_flash_upper_byte: assert property ( // [RULE_01]
        st_reg.flash_valid |-> st_reg.flash_byte == $past(rom_hi))
        else $error("flash byte not upper half of word");
    chk_flash_valid_sample: assert property ( // [RULE_02]
        s_msg_taken |-> $past(st_reg.flash_valid) &&
            st_reg.lcd.bus_out == $past(st_reg.flash_byte))
        else $error("flash byte taken without valid");
    chk_strobe_on_tick: assert property ( // [RULE_04]
        $changed(st_reg.lcd.strobe) |-> $past(tick))
        else $error("strobe moved off the divided tick");
    chk_divider_wrap: assert property ( // [RULE_13]
        st_reg.div == 7'h7f |=> st_reg.div == 7'h00 ##127 tick)
        else $error("divider period not 128");
    chk_message_once: assert property ( // [RULE_05]
        st_reg.msg_done |=> st_reg.msg_done && st_reg.fsm != S_MSG_WAIT)
        else $error("message read again");
    chk_init_command: assert property ( // [RULE_06]
        $rose(st_reg.lcd.strobe) && !st_reg.init_done |->
            st_reg.lcd.bus_out == init_cmd(st_reg.init_idx))
        else $error("wrong init command");
    chk_read_released: assert property ( // [RULE_09]
        st_reg.lcd.rw |-> st_reg.lcd.bus_oe_n && !st_reg.lcd.target_select)
        else $error("bus driven during read");
    chk_fall_latch: assert property ( // [RULE_10]
        s_strobe_fall |-> s_lines_steady)
        else $error("lines moved at strobe fall");
    chk_ack_after_lcd: assert property ( // [RULE_11]
        $fell(st_reg.ack_n) |-> $past(st_reg.fsm) == S_BUSY_LO)
        else $error("ack before byte reached display");
    chk_init_delay: assert property ( // [RULE_12]
        $past(st_reg.fsm) == S_WR_LO && st_reg.fsm != S_WR_LO |->
            (st_reg.fsm == S_DELAY) == !st_reg.init_done)
        else $error("init wait or busy poll misplaced");
    chk_row_jump: assert property ( // [RULE_08]
        $rose(st_reg.jump_pend) |-> st_reg.pos == 5'd16 || st_reg.pos == 5'd0)
        else $error("row jump at wrong position");
    chk_host_rate: assert property ( // [RULE_07]
        host_push |=> st_reg.rate_cnt == `LCD_RATE_BITS'(RATE_LAST))
        else $error("host pace counter not reloaded");

endmodule : lcd_ctrl

// >>> design/lcd_consts.svh
`ifndef LCD_CONSTS_SVH
`define LCD_CONSTS_SVH

// Timing
`define LCD_CLK_HZ 100000000
`define LCD_INIT_WAIT_MS 15
`define LCD_HOST_RATE_HZ 4250
`define LCD_DIV_BITS 7
`define LCD_WAIT_BITS 21
`define LCD_RATE_BITS 16

// Geometry
`define LCD_FIFO_DEPTH 16
`define LCD_MSG_LEN 32
`define LCD_ROW_LEN 16
`define LCD_INIT_STEPS 5
`define LCD_BUSY_BIT 7

// Register offsets
`define LCD_REG_CTRL 8'h00
`define LCD_REG_STATUS 8'h04
`define LCD_REG_CHAR 8'h08

// Field positions
`define LCD_CTRL_REINIT 0
`define LCD_CTRL_HOST_EN 1
`define LCD_ST_INIT_DONE 0
`define LCD_ST_MSG_DONE 1
`define LCD_ST_FIFO_FULL 2
`define LCD_ST_ACK 3
`define LCD_ST_POS_LSB 8

// Reset values
`define LCD_HOST_EN_RESET 1'b1

// Display commands
`define LCD_CMD_FUNC 8'h38
`define LCD_CMD_DISP 8'h0f
`define LCD_CMD_CLEAR 8'h01
`define LCD_CMD_ENTRY 8'h06
`define LCD_CMD_HOME 8'h80
`define LCD_CMD_ROW2 8'hc0

`endif

// >>> design/lcd_pkg.sv
`include "lcd_consts.svh"

package lcd_pkg;

    typedef enum logic [3:0] {
        S_IDLE,
        S_MSG_WAIT,
        S_WR_HI,
        S_WR_LO,
        S_DELAY,
        S_BUSY_SET,
        S_BUSY_HI,
        S_BUSY_LO
    } lcd_fsm_t;

    typedef struct packed {
        logic from_host;
        logic [7:0] code;
    } lcd_char_t;

    typedef struct packed {
        logic strobe;
        logic target_select;
        logic rw;
        logic [7:0] bus_out;
        logic bus_oe_n;
    } lcd_pins_t;

    typedef struct packed {
        lcd_fsm_t fsm;
        logic [`LCD_DIV_BITS-1:0] div;
        logic [`LCD_WAIT_BITS-1:0] wait_cnt;
        logic [`LCD_RATE_BITS-1:0] rate_cnt;
        logic [2:0] init_idx;
        logic [4:0] pos;
        logic [5:0] msg_idx;
        logic init_done;
        logic msg_done;
        logic jump_pend;
        logic reinit_pend;
        logic host_en;
        logic ack_n;
        logic cur_host;
        logic cur_is_cmd;
        logic [8:0] flash_addr;
        logic flash_nread;
        logic flash_valid;
        logic [7:0] flash_byte;
        logic [2:0] we_sync;
        logic we_f;
        logic [2:0][7:0] chr_sync;
        logic [7:0] chr_f;
        logic [2:0][7:0] bus_sync;
        logic [7:0] bus_f;
        lcd_pins_t lcd;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } lcd_state_t;

endpackage : lcd_pkg

// >>> design/lcd_fifo.sv
`timescale 1ns/100ps

module lcd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } lcd_fifo_state_t;

    lcd_fifo_state_t st_reg, st_next;
    logic full, empty;

    // Extra pointer bit tells full from empty
    assign empty = (st_reg.wp == st_reg.rp);
    assign full = (st_reg.wp[AW] != st_reg.rp[AW]) &&
                  (st_reg.wp[AW-1:0] == st_reg.rp[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = st_reg.mem[st_reg.rp[AW-1:0]];

    always_comb begin
        st_next = st_reg;
        if (in_valid && !full) begin
            st_next.mem[st_reg.wp[AW-1:0]] = in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (out_ready && !empty) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : lcd_fifo

// >>> testbench/lcd_char_model.sv
`timescale 1ns/100ps

module lcd_char_model (
    // Display pins
    input wire logic strobe,
    input wire logic target_select,
    input wire logic rw,
    input wire logic [7:0] bus_out,
    input wire logic bus_oe_n,
    // Bench keeps the module busy
    input wire logic stall,
    // Bus level seen by the controller
    output logic [7:0] bus_in
);
    logic [8:0] log[$];
    int polls = 0;
    bit armed = 1'b0;

    // Only a real high-to-low swing counts, not the settle out of reset
    always @(posedge strobe) armed = 1'b1;

    // Busy for two status reads per write, so the poll loop repeats
    always @(negedge strobe) begin
        if (armed && !rw) begin
            log.push_back({target_select, bus_out});
            polls = 2;
        end else if (armed && !stall && polls > 0) begin
            polls = polls - 1;
        end
        armed = 1'b0;
    end

    // Released bus outside a read shows the inverse, so a stale value cannot pass
    assign bus_in = !bus_oe_n ? bus_out :
        rw ? {polls != 0, 7'h00} : ~bus_out;
endmodule : lcd_char_model

// >>> testbench/lcd_ctrl_test.sv
`timescale 1ns/100ps
`include "lcd_consts.svh"
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin \
    n_mismatch++; $display("ERROR %0t: got %h expected %h", $time, g, x); \
    end end

module lcd_ctrl_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stall;
    logic [7:0] paddr, host_char_in, lcd_bus_in, lcd_bus_out, b;
    logic [31:0] pwdata, prdata, r;
    logic host_we_n, host_ack_n, lcd_bus_oe_n, lcd_strobe, lcd_rw, e;
    logic lcd_target_select;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;
    int rd = 0;
    string msg = {" CHARACTER  LCD ", "   CONTROLLER   "};

    lcd_ctrl #(.INIT_WAIT_CYC(20), .HOST_RATE_CYC(300), .FIFO_DEPTH(16))
    u_lcd_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .host_char_in, .host_we_n, .host_ack_n,
        .lcd_bus_in, .lcd_bus_out, .lcd_bus_oe_n, .lcd_strobe,
        .lcd_target_select, .lcd_rw);

    lcd_char_model u_lcd_char_model (.strobe(lcd_strobe),
        .target_select(lcd_target_select), .rw(lcd_rw),
        .bus_out(lcd_bus_out), .bus_oe_n(lcd_bus_oe_n), .stall(stall),
        .bus_in(lcd_bus_in));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 100000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    function automatic logic [8:0] ent(int i);
        return u_lcd_char_model.log[i];
    endfunction : ent

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_log(int n);
        while (u_lcd_char_model.log.size() < n) @(posedge pclk);
    endtask : wait_log

    // Skips row jumps; a wrong select shows as a hang
    task automatic next_data;
        logic [8:0] v;
        forever begin
            wait_log(rd + 1);
            v = ent(rd);
            rd++;
            if (v[8] === 1'b1) begin
                b = v[7:0];
                return;
            end
        end
    endtask : next_data

    task automatic check_init;
        logic [7:0] ini[5] = '{`LCD_CMD_FUNC, `LCD_CMD_DISP, `LCD_CMD_CLEAR,
            `LCD_CMD_ENTRY, `LCD_CMD_HOME};
        for (int i = 0; i < 5; i++) begin
            wait_log(rd + 1);
            `CHK(ent(rd), {1'b0, ini[i]})
            rd++;
        end
    endtask : check_init

    task automatic t_power_on;
        check_init();
        for (int i = 0; i < 32; i++) begin
            next_data();
            `CHK(b, msg[i])
            if (i % 16 == 15) begin
                wait_log(rd + 1);
                b = (i == 15) ? `LCD_CMD_ROW2 : `LCD_CMD_HOME;
                `CHK(ent(rd), {1'b0, b})
                rd++;
            end
        end
        repeat (1000) @(posedge pclk);
        apb(1'b0, `LCD_REG_STATUS, 32'h0);
        `CHK(r[1:0], 2'b11)
        apb(1'b0, `LCD_REG_CTRL, 32'h0);
        `CHK(r[1:0], 2'b10)
        apb(1'b0, 8'h0c, 32'h0);
        `CHK({e, r}, {1'b1, 32'h0})
    endtask : t_power_on

    task automatic t_host;
        `CHK(host_ack_n, 1'b0)
        host_char_in <= 8'h5a;
        host_we_n <= 1'b0;
        for (int k = 0; k < 400 && host_ack_n !== 1'b1; k++)
            @(posedge pclk);
        `CHK(host_ack_n, 1'b1)
        host_char_in <= 8'h33;
        next_data();
        `CHK(b, 8'h5a)
        next_data();
        `CHK(b, 8'h33)
        host_we_n <= 1'b1;
        repeat (2000) @(posedge pclk);
        `CHK(host_ack_n, 1'b0)
        rd = u_lcd_char_model.log.size();
    endtask : t_host

    task automatic t_fifo;
        stall <= 1'b1;
        for (int i = 0; i < 17; i++)
            apb(1'b1, `LCD_REG_CHAR, 32'h60 + i);
        // Let the first character reach the display before counting
        repeat (1000) @(posedge pclk);
        apb(1'b0, `LCD_REG_STATUS, 32'h0);
        `CHK(r[2], 1'b1)
        `CHK(u_lcd_char_model.log.size() - rd, 1)
        stall <= 1'b0;
        for (int i = 0; i < 17; i++) begin
            next_data();
            `CHK(b, 8'h60 + 8'(i))
        end
    endtask : t_fifo

    task automatic t_reinit;
        repeat (2000) @(posedge pclk);
        apb(1'b1, `LCD_REG_CTRL, 32'h3);
        check_init();
        repeat (3000) @(posedge pclk);
        `CHK(u_lcd_char_model.log.size(), rd)
        apb(1'b0, `LCD_REG_STATUS, 32'h0);
        `CHK(r[12:8], 5'h00)
    endtask : t_reinit

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        host_char_in = 8'h00;
        host_we_n = 1'b1;
        stall = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_power_on();
        t_host();
        t_fifo();
        t_reinit();
        tally_and_finish();
    end
endmodule : lcd_ctrl_test
